// *** verilog/dacb_pkg.sv ***
// Shared constants, types and helpers for the converter register bank
//==============================================================================
//==============================================================================
package dacb_pkg;

    // Clock and nonvolatile write timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int EE_WRITE_TIME_NS = 25000000;
    localparam int EE_WRITE_CYCLES = (EE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register addresses
    localparam logic [4:0] A_VOL_CODE0 = 5'h00;
    localparam logic [4:0] A_VOL_CODE1 = 5'h01;
    localparam logic [4:0] A_VOL_REF = 5'h08;
    localparam logic [4:0] A_VOL_PD = 5'h09;
    localparam logic [4:0] A_VOL_GAIN = 5'h0A;
    localparam logic [4:0] A_LOCK_STAT = 5'h0B;
    localparam logic [4:0] A_NV_CODE0 = 5'h10;
    localparam logic [4:0] A_NV_CODE1 = 5'h11;
    localparam logic [4:0] A_NV_REF = 5'h18;
    localparam logic [4:0] A_NV_PD = 5'h19;
    localparam logic [4:0] A_NV_GAIN = 5'h1A;

    // Field positions
    localparam int GAIN_LSB = 8;
    localparam int POR_FLAG_BIT = 7;
    localparam int EE_ACTIVE_BIT = 6;
    localparam int ADDR_LOCK_BIT = 7;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 7;

    // Values after reset (factory state)
    localparam logic [6:0] NV_ADDR_RESET = 7'h60;
    localparam logic ADDR_LOCK_RESET = 1'b1;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [1:0] GAIN_RESET = 2'h0;
    localparam logic [1:0] LOCK_BITS_RESET = 2'h0;

    // Lock pairs {code lock, config lock}
    localparam logic [1:0] LOCK_ALL = 2'h3;
    localparam logic [1:0] LOCK_NONE = 2'h0;

    // Reference and power-down encodings
    localparam logic [1:0] REF_PIN_BUF = 2'h3;
    localparam logic [1:0] REF_PIN_RAW = 2'h2;
    localparam logic [1:0] REF_BANDGAP = 2'h1;
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_PULL_1K = 2'h1;
    localparam logic [1:0] PD_PULL_100K = 2'h2;
    localparam logic [1:0] PD_OPEN = 2'h3;

    // Command from the serial front end
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [15:0] data;
    } dacb_cmd_t;

    // High-voltage enable or disable command
    typedef struct packed {
        logic valid;
        logic enable;
        logic [4:0] addr;
    } dacb_hv_t;

    // Answer to either command
    typedef struct packed {
        logic valid;
        logic ack;
        logic [15:0] data;
    } dacb_rsp_t;

    // Analog control lines for one channel
    typedef struct packed {
        logic refBufEn;
        logic refPin;
        logic bandgap;
        logic supply;
        logic gain2x;
        logic powered;
        logic pull1k;
        logic pull100k;
        logic open;
    } dacb_drive_t;

    // Two-bit field of one channel
    function automatic logic [1:0] chanField(input logic [3:0] word, input int ch);
        chanField = word[2*ch +: 2];
    endfunction

    // Lock gating per target kind
    function automatic logic volCodeOk(input logic [1:0] pair);
        volCodeOk = ~pair[1];
    endfunction

    function automatic logic volCfgOk(input logic [1:0] pair);
        volCfgOk = (pair != LOCK_ALL);
    endfunction

    function automatic logic nvOk(input logic [1:0] pair);
        nvOk = (pair == LOCK_NONE);
    endfunction

endpackage

// *** verilog/dacb_ee_timer.sv ***
// Nonvolatile write cycle timer
`timescale 1ns/1ps
module dacb_ee_timer #(
    parameter int CYCLES = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    output logic busy
);
    import dacb_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic busy_next;

    if (CYCLES < 1) begin : gCheck
        $error("dacb_ee_timer needs at least one cycle");
    end

    //==========================================================================
    // Countdown; a start while busy is ignored, the caller refuses it anyway
    always_comb begin
        count_next = count_reg;
        busy_next = busy;
        if (!busy && start) begin
            count_next = CW'(CYCLES);
            busy_next = 1'b1;
        end else if (busy) begin
            count_next = count_reg - 1'b1;
            busy_next = (count_reg > CW'(1));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
            busy <= 1'b0;
        end else begin
            count_reg <= count_next;
            busy <= busy_next;
        end
    end
endmodule

// *** verilog/dacb_chan_drive.sv ***
// Decode of one channel's configuration into analog controls
`timescale 1ns/1ps
module dacb_chan_drive (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] refSel,
    input wire logic [1:0] pdSel,
    input wire logic gainBit,
    output dacb_pkg::dacb_drive_t drive
);
    import dacb_pkg::*;

    dacb_drive_t drive_next;

    //==========================================================================
    // Pure decode, registered so the analog side sees clean levels
    always_comb begin
        drive_next.supply = (refSel == REF_SUPPLY);
        drive_next.bandgap = (refSel == REF_BANDGAP);
        drive_next.refPin = (refSel == REF_PIN_BUF) || (refSel == REF_PIN_RAW);
        drive_next.refBufEn = (refSel == REF_PIN_BUF) || (refSel == REF_BANDGAP);
        // Doubling the supply rail is meaningless, so it is suppressed
        drive_next.gain2x = gainBit && (refSel != REF_SUPPLY);
        drive_next.powered = (pdSel == PD_NORMAL);
        drive_next.pull1k = (pdSel == PD_PULL_1K);
        drive_next.pull100k = (pdSel == PD_PULL_100K);
        drive_next.open = (pdSel == PD_OPEN);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive <= '0;
        end else begin
            drive <= drive_next;
        end
    end
endmodule

// *** verilog/dacb_reg_bank.sv ***
// Volatile and nonvolatile register bank with lock gating
`timescale 1ns/1ps
module dacb_reg_bank #(
    parameter int CODE_W = 12,
    parameter int CH = 2,
    parameter int EE_CYCLES = dacb_pkg::EE_WRITE_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire dacb_pkg::dacb_cmd_t cmd,
    input wire dacb_pkg::dacb_hv_t hvCmd,
    input wire logic highVoltagePin,
    output dacb_pkg::dacb_rsp_t rsp,
    output logic [CH*CODE_W-1:0] outCode,
    output dacb_pkg::dacb_drive_t [CH-1:0] chanDrive,
    output logic [6:0] busAddressBits,
    output logic eepromWriteActive
);
    import dacb_pkg::*;

    typedef enum logic {
        ST_RECALL,
        ST_RUN
    } dacb_state_t;

    localparam logic [CODE_W-1:0] MID_CODE = {1'b0, {(CODE_W-1){1'b1}}};
    localparam logic [CODE_W-1:0] ONES_CODE = {CODE_W{1'b1}};

    if (!(CODE_W == 8 || CODE_W == 10 || CODE_W == 12) || !(CH == 1 || CH == 2)) begin : gCheck
        $error("dacb_reg_bank supports 8/10/12-bit codes and one or two channels");
    end

    dacb_state_t state_reg;
    dacb_state_t state_next;
    logic [CODE_W-1:0] volCode_reg [CH];
    logic [CODE_W-1:0] volCode_next [CH];
    logic [CODE_W-1:0] nvCode_reg [CH];
    logic [CODE_W-1:0] nvCode_next [CH];
    logic [3:0] volRef_reg;
    logic [3:0] volRef_next;
    logic [3:0] nvRef_reg;
    logic [3:0] nvRef_next;
    logic [3:0] volPd_reg;
    logic [3:0] volPd_next;
    logic [3:0] nvPd_reg;
    logic [3:0] nvPd_next;
    logic [1:0] volGain_reg;
    logic [1:0] volGain_next;
    logic [1:0] nvGain_reg;
    logic [1:0] nvGain_next;
    logic porFlag_reg;
    logic porFlag_next;
    logic [6:0] nvAddr_reg;
    logic [6:0] nvAddr_next;
    logic addrLock_reg;
    logic addrLock_next;
    logic [1:0] codeLock_reg;
    logic [1:0] codeLock_next;
    logic [1:0] cfgLock_reg;
    logic [1:0] cfgLock_next;
    dacb_rsp_t rsp_next;
    logic eeStart;
    logic eeBusy;
    logic [2:0] hvcSync_reg;
    logic [2:0] hvcSync_next;
    logic hvcLevel_reg;
    logic hvcLevel_next;
    logic [3:0] chMask;

    // Bits of a two-bit-per-channel word that exist on this part
    assign chMask = (CH == 2) ? 4'hF : 4'h3;

    //==========================================================================
    // High-voltage pin: three flops, a change counts once stages 2 and 3 agree
    always_comb begin
        hvcSync_next = {hvcSync_reg[1:0], highVoltagePin};
        hvcLevel_next = (hvcSync_reg[1] == hvcSync_reg[2]) ? hvcSync_reg[2] : hvcLevel_reg;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hvcSync_reg <= 3'h0;
            hvcLevel_reg <= 1'b0;
        end else begin
            hvcSync_reg <= hvcSync_next;
            hvcLevel_reg <= hvcLevel_next;
        end
    end

    //==========================================================================
    // Command handling; a blocked or refused command changes nothing
    always_comb begin
        logic [1:0] pair;
        logic blocked;
        logic isNv;
        int ch;
        pair = LOCK_NONE;
        blocked = 1'b0;
        isNv = cmd.addr[4];
        ch = 0;
        state_next = state_reg;
        volCode_next = volCode_reg;
        nvCode_next = nvCode_reg;
        volRef_next = volRef_reg;
        nvRef_next = nvRef_reg;
        volPd_next = volPd_reg;
        nvPd_next = nvPd_reg;
        volGain_next = volGain_reg;
        nvGain_next = nvGain_reg;
        porFlag_next = porFlag_reg;
        nvAddr_next = nvAddr_reg;
        addrLock_next = addrLock_reg;
        codeLock_next = codeLock_reg;
        cfgLock_next = cfgLock_reg;
        eeStart = 1'b0;
        rsp_next = '0;
        if (state_reg == ST_RECALL) begin
            // One cycle after release the stored copies become live
            volCode_next = nvCode_reg;
            volRef_next = nvRef_reg;
            volPd_next = nvPd_reg;
            volGain_next = nvGain_reg;
            state_next = ST_RUN;
        end else if (cmd.valid) begin
            rsp_next.valid = 1'b1;
            rsp_next.ack = 1'b1;
            // Nonvolatile targets are off limits while the write cycle runs
            if (isNv && eeBusy) begin
                rsp_next.ack = 1'b0;
            end else if (!cmd.write) begin
                case (cmd.addr)
                    A_VOL_CODE0, A_VOL_CODE1: begin
                        ch = int'(cmd.addr[0]);
                        if (ch < CH) begin
                            rsp_next.data = 16'(volCode_reg[ch]);
                        end else begin
                            rsp_next.ack = 1'b0;
                            rsp_next.data = 16'(ONES_CODE);
                        end
                    end
                    A_NV_CODE0, A_NV_CODE1: begin
                        ch = int'(cmd.addr[0]);
                        if (ch < CH) begin
                            rsp_next.data = 16'(nvCode_reg[ch]);
                        end else begin
                            rsp_next.ack = 1'b0;
                            rsp_next.data = 16'(ONES_CODE);
                        end
                    end
                    A_VOL_REF: rsp_next.data = {12'h000, volRef_reg & chMask};
                    A_NV_REF: rsp_next.data = {12'h000, nvRef_reg & chMask};
                    A_VOL_PD: rsp_next.data = {12'h000, volPd_reg & chMask};
                    A_NV_PD: rsp_next.data = {12'h000, nvPd_reg & chMask};
                    A_VOL_GAIN: begin
                        rsp_next.data[GAIN_LSB +: 2] = volGain_reg & chMask[1:0];
                        rsp_next.data[POR_FLAG_BIT] = porFlag_reg;
                        rsp_next.data[EE_ACTIVE_BIT] = eeBusy;
                        porFlag_next = 1'b0;
                    end
                    A_NV_GAIN: begin
                        rsp_next.data[GAIN_LSB +: 2] = nvGain_reg & chMask[1:0];
                        rsp_next.data[ADDR_LOCK_BIT] = addrLock_reg;
                        rsp_next.data[ADDR_LSB +: ADDR_W] = nvAddr_reg;
                    end
                    A_LOCK_STAT: begin
                        for (int i = 0; i < CH; i++) begin
                            rsp_next.data[2*i +: 2] = {codeLock_reg[i], cfgLock_reg[i]};
                        end
                    end
                    default: begin
                        rsp_next.ack = 1'b0;
                        rsp_next.data = 16'(ONES_CODE);
                    end
                endcase
            end else begin
                case (cmd.addr)
                    A_VOL_CODE0, A_VOL_CODE1, A_NV_CODE0, A_NV_CODE1: begin
                        ch = int'(cmd.addr[0]);
                        if (ch < CH) begin
                            pair = {codeLock_reg[ch], cfgLock_reg[ch]};
                            blocked = isNv ? !nvOk(pair) : !volCodeOk(pair);
                            if (blocked) begin
                                rsp_next.ack = 1'b0;
                            end else if (isNv) begin
                                // Live output keeps its value until the next recall
                                nvCode_next[ch] = cmd.data[CODE_W-1:0];
                                eeStart = 1'b1;
                            end else begin
                                volCode_next[ch] = cmd.data[CODE_W-1:0];
                            end
                        end else begin
                            rsp_next.ack = 1'b0;
                        end
                    end
                    A_VOL_REF, A_VOL_PD, A_NV_REF, A_NV_PD: begin
                        // Only a channel whose field would change is checked
                        for (int i = 0; i < CH; i++) begin
                            pair = {codeLock_reg[i], cfgLock_reg[i]};
                            if (chanField(cmd.data[3:0], i) != chanField(
                                    cmd.addr[0] ? (isNv ? nvPd_reg : volPd_reg)
                                                : (isNv ? nvRef_reg : volRef_reg), i) &&
                                    !(isNv ? nvOk(pair) : volCfgOk(pair))) begin
                                blocked = 1'b1;
                            end
                        end
                        if (blocked) begin
                            rsp_next.ack = 1'b0;
                        end else begin
                            case ({isNv, cmd.addr[0]})
                                2'b00: volRef_next = cmd.data[3:0] & chMask;
                                2'b01: volPd_next = cmd.data[3:0] & chMask;
                                2'b10: nvRef_next = cmd.data[3:0] & chMask;
                                default: nvPd_next = cmd.data[3:0] & chMask;
                            endcase
                            eeStart = isNv;
                        end
                    end
                    A_VOL_GAIN, A_NV_GAIN: begin
                        for (int i = 0; i < CH; i++) begin
                            pair = {codeLock_reg[i], cfgLock_reg[i]};
                            if (cmd.data[GAIN_LSB + i] != (isNv ? nvGain_reg[i] : volGain_reg[i]) &&
                                    !(isNv ? nvOk(pair) : volCfgOk(pair))) begin
                                blocked = 1'b1;
                            end
                        end
                        // Locked address accepts only its own value back
                        if (isNv && addrLock_reg &&
                                cmd.data[ADDR_LSB +: ADDR_W] != nvAddr_reg) begin
                            blocked = 1'b1;
                        end
                        if (blocked) begin
                            rsp_next.ack = 1'b0;
                        end else if (isNv) begin
                            nvGain_next = cmd.data[GAIN_LSB +: 2] & chMask[1:0];
                            nvAddr_next = cmd.data[ADDR_LSB +: ADDR_W];
                            eeStart = 1'b1;
                        end else begin
                            volGain_next = cmd.data[GAIN_LSB +: 2] & chMask[1:0];
                        end
                    end
                    default: rsp_next.ack = 1'b0;
                endcase
            end
        end else if (hvCmd.valid) begin
            rsp_next.valid = 1'b1;
            // Lock bits are nonvolatile: pin high and no write cycle running
            rsp_next.ack = hvcLevel_reg && !eeBusy;
            case (hvCmd.addr)
                A_VOL_CODE0, A_VOL_CODE1: begin
                    if (int'(hvCmd.addr[0]) < CH && rsp_next.ack) begin
                        cfgLock_next[hvCmd.addr[0]] = hvCmd.enable;
                    end else begin
                        rsp_next.ack = 1'b0;
                    end
                end
                A_NV_CODE0, A_NV_CODE1: begin
                    if (int'(hvCmd.addr[0]) < CH && rsp_next.ack) begin
                        codeLock_next[hvCmd.addr[0]] = hvCmd.enable;
                    end else begin
                        rsp_next.ack = 1'b0;
                    end
                end
                A_NV_GAIN: begin
                    if (rsp_next.ack) begin
                        addrLock_next = hvCmd.enable;
                    end
                end
                default: rsp_next.ack = 1'b0;
            endcase
            eeStart = rsp_next.ack;
        end
    end

    //==========================================================================
    // Bank registers; reset stands for power-on or brown-out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RECALL;
            for (int i = 0; i < CH; i++) begin
                volCode_reg[i] <= '0; // Blank until the recall fills it, so a lost recall shows
                nvCode_reg[i] <= MID_CODE;
            end
            volRef_reg <= SEL_RESET;
            nvRef_reg <= SEL_RESET;
            volPd_reg <= SEL_RESET;
            nvPd_reg <= SEL_RESET;
            volGain_reg <= GAIN_RESET;
            nvGain_reg <= GAIN_RESET;
            porFlag_reg <= 1'b1;
            nvAddr_reg <= NV_ADDR_RESET;
            addrLock_reg <= ADDR_LOCK_RESET;
            codeLock_reg <= LOCK_BITS_RESET;
            cfgLock_reg <= LOCK_BITS_RESET;
            rsp <= '0;
            outCode <= '0;
            busAddressBits <= NV_ADDR_RESET;
        end else begin
            state_reg <= state_next;
            volCode_reg <= volCode_next;
            nvCode_reg <= nvCode_next;
            volRef_reg <= volRef_next;
            nvRef_reg <= nvRef_next;
            volPd_reg <= volPd_next;
            nvPd_reg <= nvPd_next;
            volGain_reg <= volGain_next;
            nvGain_reg <= nvGain_next;
            porFlag_reg <= porFlag_next;
            nvAddr_reg <= nvAddr_next;
            addrLock_reg <= addrLock_next;
            codeLock_reg <= codeLock_next;
            cfgLock_reg <= cfgLock_next;
            rsp <= rsp_next;
            for (int i = 0; i < CH; i++) begin
                outCode[i*CODE_W +: CODE_W] <= volCode_next[i];
            end
            busAddressBits <= nvAddr_next;
        end
    end

    //==========================================================================
    // Write cycle timer and per-channel analog decode
    dacb_ee_timer #(
        .CYCLES(EE_CYCLES)
    ) uTimer (
        .clock(clock),
        .rst(rst),
        .start(eeStart),
        .busy(eeBusy)
    );

    assign eepromWriteActive = eeBusy;

    for (genvar g = 0; g < CH; g++) begin : gChan
        dacb_chan_drive uDrive (
            .clock(clock),
            .rst(rst),
            .refSel(chanField(volRef_reg, g)),
            .pdSel(chanField(volPd_reg, g)),
            .gainBit(volGain_reg[g]),
            .drive(chanDrive[g])
        );
    end
endmodule

// *** verification/dacb_props.sv ***
// Port checks for the converter register bank
`timescale 1ns/1ps
module dacb_props #(parameter int CODE_W = 12, parameter int CH = 2, parameter int EE_CYCLES = 8) (
    input wire logic clock,
    input wire logic rst,
    input wire dacb_pkg::dacb_cmd_t cmd,
    input wire dacb_pkg::dacb_hv_t hvCmd,
    input wire logic highVoltagePin,
    input wire dacb_pkg::dacb_rsp_t rsp,
    input wire logic [CH*CODE_W-1:0] outCode,
    input wire dacb_pkg::dacb_drive_t [CH-1:0] chanDrive,
    input wire logic [6:0] busAddressBits,
    input wire logic eepromWriteActive
);
    import dacb_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    //====================
    // Answers and refusals
    property p_ans; (cmd.valid || hvCmd.valid) |=> rsp.valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_busy; eepromWriteActive && cmd.valid && cmd.addr[4] |=> !rsp.ack; endproperty
    a_busy: assert property (p_busy) else $error("stored access during write");
    property p_up; cmd.valid && !cmd.write && cmd.addr == A_VOL_CODE0 |=> rsp.data >> CODE_W == 0;
    endproperty
    a_up: assert property (p_up) else $error("code upper bits set");
    // Stored writes must not disturb the live code
    property p_nv; cmd.valid && cmd.write && cmd.addr == A_NV_CODE0 |=> $stable(outCode); endproperty
    a_nv: assert property (p_nv) else $error("live code moved");
    // Pin must be up for several edges, so a short glitch cannot unlock anything
    property p_hv; (!highVoltagePin) [*5] ##0 (hvCmd.valid && !cmd.valid) |=> !rsp.ack; endproperty
    a_hv: assert property (p_hv) else $error("lock change without pin");
    property p_addr; $changed(busAddressBits) |-> rsp.valid && rsp.ack; endproperty
    a_addr: assert property (p_addr) else $error("address changed unasked");
    //====================
    // Decode sanity; the one-hot check is skipped until decode has settled after reset
    property p_unity; chanDrive[0].supply |-> !chanDrive[0].gain2x; endproperty
    a_unity: assert property (p_unity) else $error("gain on supply ref");
    property p_pd; !$past(rst, 2) |-> $onehot({chanDrive[0].powered, chanDrive[0].pull1k,
        chanDrive[0].pull100k, chanDrive[0].open}); endproperty
    a_pd: assert property (p_pd) else $error("power mode not one-hot");
    c_nack: cover property (rsp.valid && !rsp.ack);
    c_busy: cover property ($rose(eepromWriteActive));
    c_hv: cover property (hvCmd.valid && highVoltagePin);
endmodule

// *** verification/dacb_host.sv ***
// Serial front-end model that issues commands to the bank
`timescale 1ns/1ps
module dacb_host (
    input wire logic clock,
    output dacb_pkg::dacb_cmd_t cmd,
    output dacb_pkg::dacb_hv_t hvCmd,
    input wire dacb_pkg::dacb_rsp_t rsp
);
    import dacb_pkg::*;
    initial cmd = '0;
    initial hvCmd = '0;
    // One pulse, then released lines invert so stale values never look valid
    task automatic xfer(input logic h, w, input logic [4:0] a, input logic [15:0] d,
        output logic ack, output logic [15:0] q, output bit ok);
        int n;
        ok = 0;
        @(posedge clock) #1;
        if (h) hvCmd <= '{1'b1, w, a};
        else cmd <= '{1'b1, w, a, d};
        @(posedge clock) #1;
        cmd <= '{1'b0, ~cmd.write, ~cmd.addr, ~cmd.data};
        hvCmd <= '{1'b0, ~hvCmd.enable, ~hvCmd.addr};
        for (n = 0; n < 4 && !ok; n++) begin
            if (rsp.valid === 1'b1) begin
                ok = 1;
                ack = rsp.ack;
                q = rsp.data;
            end else @(posedge clock) #1;
        end
    endtask
endmodule

// *** verification/test_dac_config_register_bank.sv ***
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin \
    $display("BAD %s exp %h seen %h", n, e, s); err_total++; end end
module test_dac_config_register_bank;
    import dacb_pkg::*;
    typedef struct packed {logic w; logic [4:0] a; logic [15:0] d; logic k; logic [15:0] e;} dacb_row_t;
    logic clock = 0, rst = 1, highVoltagePin = 0, eepromWriteActive, ack;
    dacb_cmd_t cmd;
    dacb_hv_t hvCmd;
    dacb_rsp_t rsp;
    logic [23:0] outCode;
    dacb_drive_t [1:0] chanDrive;
    logic [6:0] busAddressBits;
    logic [15:0] q;
    bit ok;
    int err_total = 0, checks_done = 0;
    dacb_row_t rows [13];
    always #4 clock = ~clock;
    // Short write window keeps the busy phases to a few cycles
    dacb_reg_bank #(.EE_CYCLES(8)) dut_u (.clock(clock), .rst(rst), .cmd(cmd), .hvCmd(hvCmd),
        .highVoltagePin(highVoltagePin), .rsp(rsp), .outCode(outCode), .chanDrive(chanDrive),
        .busAddressBits(busAddressBits), .eepromWriteActive(eepromWriteActive));
    dacb_host host_u (.clock(clock), .cmd(cmd), .hvCmd(hvCmd), .rsp(rsp));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // A lost answer ends the run at once
    task automatic go(input logic h, w, input logic [4:0] a, input logic [15:0] d, input logic k);
        host_u.xfer(h, w, a, d, ack, q, ok);
        if (!ok) begin err_total++; complete_run(); end
        else `CHK("ack", k, ack)
    endtask
    initial begin
        rows = '{'{0, 5'h00, 0, 1, 16'h07FF},
            '{0, 5'h0A, 0, 1, 16'h0080}, '{0, 5'h0A, 0, 1, 16'h0000},
            '{1, 5'h00, 16'hFFFF, 1, 0}, '{0, 5'h00, 0, 1, 16'h0FFF},
            '{1, 5'h08, 16'h00FF, 1, 0}, '{0, 5'h08, 0, 1, 16'h000F},
            '{1, 5'h0A, 16'h0300, 1, 0}, '{0, 5'h0A, 0, 1, 16'h0300},
            '{1, 5'h08, 0, 1, 0}, '{0, 5'h0C, 0, 0, 16'h0FFF},
            '{0, 5'h1A, 0, 1, 16'h00E0}, '{1, 5'h1A, 16'h0055, 0, 0}};
        repeat (10) @(posedge clock);
        #1 rst = 0;
        repeat (2) @(posedge clock);
        foreach (rows[i]) begin
            go(0, rows[i].w, rows[i].a, rows[i].d, rows[i].k);
            `CHK("data", rows[i].e, q)
        end
        $display("table done");
        go(1, 0, 5'h1A, 0, 0);
        highVoltagePin = 1;
        repeat (5) @(posedge clock);
        go(1, 0, 5'h1A, 0, 1);
        repeat (12) @(posedge clock);
        go(0, 1, A_NV_GAIN, 16'h0055, 1);
        `CHK("addr", 7'h55, busAddressBits)
        // Each lock pair against each kind of target, config value always changing
        for (int p = 0; p < 4; p++) begin
            repeat (12) @(posedge clock);
            go(1, p[0], 5'h00, 0, 1);
            repeat (12) @(posedge clock);
            go(1, p[1], 5'h10, 0, 1);
            repeat (12) @(posedge clock);
            go(0, 0, A_LOCK_STAT, 0, 1);
            `CHK("lock", 2'(p), q[1:0])
            go(0, 1, A_VOL_CODE0, 16'(p), !p[1]);
            go(0, 1, A_VOL_PD, 16'(p ^ 3), p != 3);
            go(0, 1, A_NV_CODE0, 16'h0123, p == 0);
            go(0, 0, A_NV_REF, 0, p != 0);
            go(0, 0, A_VOL_GAIN, 0, 1);
            `CHK("busy", (p == 0) ? 16'h0340 : 16'h0300, q)
            `CHK("active", p == 0, eepromWriteActive)
        end
        // Channel 0 is fully locked but its field stays the same, so this is taken
        go(0, 1, A_VOL_REF, 16'h0004, 1);
        @(posedge clock) #1;
        `CHK("gain", 1'b1, chanDrive[1].gain2x)
        `CHK("unity", 1'b0, chanDrive[0].gain2x)
        `CHK("pull", 1'b1, chanDrive[0].pull1k)
        $display("lock done");
        rst = 1;
        repeat (2) @(posedge clock);
        #1 rst = 0;
        repeat (3) @(posedge clock);
        #1 `CHK("recall", 12'h7FF, outCode[11:0])
        go(0, 0, A_VOL_GAIN, 0, 1);
        `CHK("flag", 16'h0080, q)
        $display("reset done");
        complete_run();
    end
endmodule
bind dacb_reg_bank dacb_props #(.CODE_W(CODE_W), .CH(CH), .EE_CYCLES(EE_CYCLES)) props_u (
    .clock(clock), .rst(rst), .cmd(cmd), .hvCmd(hvCmd), .highVoltagePin(highVoltagePin),
    .rsp(rsp), .outCode(outCode), .chanDrive(chanDrive), .busAddressBits(busAddressBits),
    .eepromWriteActive(eepromWriteActive));
